// *** src/plectl_pkg.sv ***
package plectl_pkg;

    // ------------------------------------------------------------------
    // coprocessor operation selectors
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,
        OP_RD_ID,
        OP_RD_ACTIVITY,
        OP_RD_FREE,
        OP_RD_USER_ACCESS,
        OP_WR_USER_ACCESS,
        OP_RD_PARAM,
        OP_WR_PARAM,
        OP_FLUSH,
        OP_PAUSE,
        OP_RESUME,
        OP_KILL,
        OP_PROGRAM
    } plectl_op_t;

    // ------------------------------------------------------------------
    // register fields
    // ------------------------------------------------------------------
    localparam int UA_EN_BIT   = 0;
    localparam int PC_BSZ_HI   = 29;
    localparam int PC_BSZ_LO   = 16;
    localparam int PC_BNM_HI   = 15;
    localparam int PC_BNM_LO   = 8;
    localparam int PC_WS_HI    = 7;
    localparam int PC_WS_LO    = 0;
    localparam int ID_SIZE_LO  = 16;
    localparam int ID_PRES_BIT = 0;

    localparam logic [31:0] UA_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_WMASK = 32'h3fff_ffff;

    // ------------------------------------------------------------------
    // channel descriptor fields
    // ------------------------------------------------------------------
    localparam int DS_BASE_HI = 63;
    localparam int DS_BASE_LO = 34;
    localparam int DS_LEN_HI  = 31;
    localparam int DS_LEN_LO  = 18;
    localparam int DS_STR_HI  = 17;
    localparam int DS_STR_LO  = 10;
    localparam int DS_NUM_HI  = 9;
    localparam int DS_NUM_LO  = 2;

    localparam int LEN_W  = 14;
    localparam int STR_W  = 8;
    localparam int NUM_W  = 8;
    localparam int ADDR_W = 32;
    localparam int ENTRY_W = 30 + LEN_W + STR_W + NUM_W;

    // ------------------------------------------------------------------
    // sizing
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam int LINE_WORDS = 8;
    localparam logic [ADDR_W-1:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] LINE_BYTES = 32'h0000_0020;

endpackage

// *** src/plectl_queue.sv ***
`timescale 1ns/1ps

// channel queue; flush clears everything, kill is handled by the caller
module plectl_queue (
    input  wire logic                                mclk,
    input  wire logic                                rst,
    input  wire logic                                push,
    input  wire logic [plectl_pkg::ENTRY_W-1:0]      push_data,
    input  wire logic                                pop,
    input  wire logic                                flush,
    output logic      [plectl_pkg::ENTRY_W-1:0]      head_data,
    output logic                                     not_empty,
    output logic                                     full,
    output logic      [4:0]                          free_count
);
    localparam int PW = $clog2(plectl_pkg::FIFO_DEPTH);

    logic [plectl_pkg::ENTRY_W-1:0] mem_q [plectl_pkg::FIFO_DEPTH];
    logic [PW-1:0]                  rd_q;
    logic [PW-1:0]                  wr_q;
    logic [PW:0]                    cnt_q;
    logic                           do_push;
    logic                           do_pop;

    assign full       = (cnt_q == (PW+1)'(plectl_pkg::FIFO_DEPTH));
    assign not_empty  = (cnt_q != '0);
    assign do_push    = push && !full && !flush;
    assign do_pop     = pop && not_empty && !flush;
    assign head_data  = mem_q[rd_q];
    assign free_count = 5'(plectl_pkg::FIFO_DEPTH) - 5'(cnt_q);

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem_q[wr_q] <= push_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end
endmodule

// *** src/plectl_pacer.sv ***
`timescale 1ns/1ps

// counts idle cycles between line requests
module plectl_pacer (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] wait_states,
    input  wire logic       issued,
    output logic            ready
);
    logic [7:0] cnt_q;

    assign ready = (cnt_q == 8'h00);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (issued) begin
            cnt_q <= wait_states;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// *** src/plectl_top.sv ***
`timescale 1ns/1ps

// Functional notes
// [RL1] user access bit 0 lets user mode use engine; upper bits read zero
// [RL2] without engine present, every engine op raises undefined instruction; the code still accepts ID, activity and free entry reads
// [RL3] parameter control register is privileged only; bits 31:30 read zero
// [RL4] effective length is programmed length ANDed with block size mask
// [RL5] effective count is count ANDed with block number mask; zero mask one block
// [RL6] wait-state field inserts that many idle cycles between line requests
// [RL7] all ones gives one request per 256 cycles; zero one per cycle; the code spaces answered requests at least wait states plus 2 cycles apart
// [RL8] nonsecure ops gated by nonsecure permit, user ops by user access bit
// [RL9] flush discards queue and active channel, source value ignored
// [RL10] pause stops activity, even with no active channel
// [RL11] resume restarts paused engine, otherwise ignored
// [RL12] kill ends active channel only; queued entries stay
// [RL13] program queues a new region and kills the active channel
// [RL14] descriptor bits 63:34 word base address; 33:32 ignored
// [RL15] bits 31:18 length minus one in words
// [RL16] bits 17:10 stride in words between blocks
// [RL17] bits 9:2 block count minus one; 1:0 ignored
// [RL18] program only writes when entry free; overflow drops and pulses event
// [RL19] free entry status reports depth minus programmed entries
// [RL20] queue depth is a build choice of 4, 8 or 16
// [RL21] activity bit reads 1 while engine handles a request
// [RL22] translation abort drops that request and moves to the next
// [RL23] walk each block line by line, stepping base by stride, then next entry
module plectl_top #(
    parameter bit ENGINE_PRESENT = 1'b1
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          op_valid,
    input  wire plectl_pkg::plectl_op_t        op_sel,
    input  wire logic [31:0]                   op_wdata_lo,
    input  wire logic [31:0]                   op_wdata_hi,
    input  wire logic                          op_privileged,
    input  wire logic                          op_nonsecure,
    input  wire logic                          nonsecure_preload_permit,
    output logic                               op_done,
    output logic                               op_undef,
    output logic [31:0]                        op_rdata,
    output logic                               line_prefetch_request,
    output logic [31:0]                        line_prefetch_addr,
    input  wire logic                          line_prefetch_accept,
    input  wire logic                          line_prefetch_abort,
    output logic                               fifo_overflow_event,
    output logic                               activity_status,
    output logic                               paused
);
    // ------------------------------------------------------------------
    // local types and state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_ISSUE
    } plectl_state_t;

    plectl_state_t                   state_q;
    logic [31:0]                     user_access_q;
    logic [31:0]                     param_q;
    logic                            paused_q;
    logic                            op_done_q;
    logic                            op_undef_q;
    logic [31:0]                     op_rdata_q;
    logic                            ovf_q;
    logic [31:0]                     block_base_q;
    logic [31:0]                     line_addr_q;
    logic [31:0]                     block_end_q;
    logic [7:0]                      stride_q;
    logic [7:0]                      blocks_left_q;
    logic [13:0]                     len_q;
    logic                            req_q;

    logic                            allowed;
    logic                            priv_only;
    logic                            accept_op;
    logic                            do_flush;
    logic                            do_kill;
    logic                            do_push;
    logic                            q_pop;
    logic [plectl_pkg::ENTRY_W-1:0]  push_data;
    logic [plectl_pkg::ENTRY_W-1:0]  head;
    logic                            q_not_empty;
    logic                            q_full;
    logic [4:0]                      free_cnt;
    logic                            pace_ready;
    logic                            line_done;
    logic                            last_line;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] words_to_bytes(input logic [13:0] w);
        words_to_bytes = {16'h0000, 2'b00, w} * plectl_pkg::WORD_BYTES;
    endfunction

    function automatic logic [4:0] size_code(input int depth);
        size_code = 5'(depth);
    endfunction

    // ------------------------------------------------------------------
    // access checks
    // ------------------------------------------------------------------
    // privileged register ignores user access bit
    assign priv_only = (op_sel == plectl_pkg::OP_RD_PARAM) ||
                       (op_sel == plectl_pkg::OP_WR_PARAM);
    always_comb begin
        allowed = 1'b1;
        if (!ENGINE_PRESENT && op_sel != plectl_pkg::OP_RD_ID &&
            op_sel != plectl_pkg::OP_RD_ACTIVITY && op_sel != plectl_pkg::OP_RD_FREE) begin
            allowed = 1'b0; // RL2
        end
        if (priv_only && !op_privileged) begin
            allowed = 1'b0; // RL3
        end
        if (!op_privileged && !user_access_q[plectl_pkg::UA_EN_BIT] &&
            op_sel >= plectl_pkg::OP_WR_USER_ACCESS && !priv_only) begin
            allowed = 1'b0; // RL1 RL8
        end
        if (op_nonsecure && !nonsecure_preload_permit &&
            op_sel >= plectl_pkg::OP_RD_FREE) begin
            allowed = 1'b0; // RL8
        end
    end

    assign accept_op = op_valid && allowed;
    assign do_flush  = accept_op && op_sel == plectl_pkg::OP_FLUSH; // RL9
    assign do_kill   = accept_op && (op_sel == plectl_pkg::OP_KILL ||
                                     op_sel == plectl_pkg::OP_PROGRAM); // RL12 RL13
    assign do_push   = accept_op && op_sel == plectl_pkg::OP_PROGRAM && !q_full; // RL18

    // descriptor packing, ignored bits dropped
    assign push_data = {op_wdata_hi[plectl_pkg::DS_BASE_HI-32:plectl_pkg::DS_BASE_LO-32],
                        op_wdata_lo[plectl_pkg::DS_LEN_HI:plectl_pkg::DS_LEN_LO],
                        op_wdata_lo[plectl_pkg::DS_STR_HI:plectl_pkg::DS_STR_LO],
                        op_wdata_lo[plectl_pkg::DS_NUM_HI:plectl_pkg::DS_NUM_LO]}; // RL14 RL15 RL16 RL17

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            user_access_q <= plectl_pkg::UA_RESET;
            param_q       <= plectl_pkg::PC_RESET;
        end else if (accept_op) begin
            if (op_sel == plectl_pkg::OP_WR_USER_ACCESS) begin
                user_access_q <= {31'h0, op_wdata_lo[plectl_pkg::UA_EN_BIT]}; // RL1
            end
            if (op_sel == plectl_pkg::OP_WR_PARAM) begin
                param_q <= op_wdata_lo & plectl_pkg::PC_WMASK; // RL3
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            op_done_q  <= 1'b0;
            op_undef_q <= 1'b0;
            op_rdata_q <= 32'h0000_0000;
        end else begin
            op_done_q  <= op_valid && allowed;
            op_undef_q <= op_valid && !allowed; // RL2
            op_rdata_q <= 32'h0000_0000;
            if (accept_op) begin
                case (op_sel)
                    plectl_pkg::OP_RD_ID: begin
                        if (ENGINE_PRESENT) begin
                            op_rdata_q <= (32'(size_code(plectl_pkg::FIFO_DEPTH))
                                           << plectl_pkg::ID_SIZE_LO) | 32'h0000_0001; // RL20
                        end
                    end
                    plectl_pkg::OP_RD_ACTIVITY: op_rdata_q <= {31'h0, activity_status}; // RL21
                    plectl_pkg::OP_RD_FREE:     op_rdata_q <= {27'h0, free_cnt}; // RL19
                    plectl_pkg::OP_RD_USER_ACCESS: op_rdata_q <= user_access_q; // RL1
                    plectl_pkg::OP_RD_PARAM:    op_rdata_q <= param_q; // RL3
                    default:                    op_rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign op_done  = op_done_q;
    assign op_undef = op_undef_q;
    assign op_rdata = op_rdata_q;

    // overflow event: one cycle pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= accept_op && op_sel == plectl_pkg::OP_PROGRAM && q_full; // RL18
        end
    end
    assign fifo_overflow_event = ovf_q;

    // ------------------------------------------------------------------
    // pause and resume
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            paused_q <= 1'b0;
        end else if (accept_op && op_sel == plectl_pkg::OP_PAUSE) begin
            paused_q <= 1'b1; // RL10
        end else if (accept_op && op_sel == plectl_pkg::OP_RESUME && paused_q) begin
            paused_q <= 1'b0; // RL11
        end
    end
    assign paused = paused_q;

    // ------------------------------------------------------------------
    // channel queue and pacing
    // ------------------------------------------------------------------
    plectl_queue u_queue (
        .mclk       (mclk),
        .rst        (rst),
        .push       (do_push),
        .push_data  (push_data),
        .pop        (q_pop),
        .flush      (do_flush),
        .head_data  (head),
        .not_empty  (q_not_empty),
        .full       (q_full),
        .free_count (free_cnt)
    );

    plectl_pacer u_pacer (
        .mclk        (mclk),
        .rst         (rst),
        .wait_states (param_q[plectl_pkg::PC_WS_HI:plectl_pkg::PC_WS_LO]), // RL6 RL7
        .issued      (line_done),
        .ready       (pace_ready)
    );

    // ------------------------------------------------------------------
    // channel walker
    // ------------------------------------------------------------------
    // an abort counts as done so the walk moves on
    assign line_done = req_q && (line_prefetch_accept || line_prefetch_abort); // RL22
    assign last_line = (line_addr_q + plectl_pkg::LINE_BYTES) >= block_end_q;
    assign q_pop     = (state_q == ST_IDLE) && q_not_empty && !paused_q && !do_flush && !do_kill;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q       <= ST_IDLE;
            req_q         <= 1'b0;
            block_base_q  <= 32'h0000_0000;
            line_addr_q   <= 32'h0000_0000;
            block_end_q   <= 32'h0000_0000;
            stride_q      <= 8'h00;
            blocks_left_q <= 8'h00;
            len_q         <= 14'h0000;
        end else if (do_flush || do_kill) begin
            state_q <= ST_IDLE; // RL9 RL12 RL13
            req_q   <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (q_pop) begin
                        block_base_q  <= {head[plectl_pkg::ENTRY_W-1 -: 30], 2'b00}; // RL14
                        stride_q      <= head[plectl_pkg::NUM_W +: plectl_pkg::STR_W];
                        len_q         <= head[plectl_pkg::NUM_W+plectl_pkg::STR_W +: 14]
                                         & param_q[plectl_pkg::PC_BSZ_HI:plectl_pkg::PC_BSZ_LO]; // RL4
                        blocks_left_q <= head[plectl_pkg::NUM_W-1:0]
                                         & param_q[plectl_pkg::PC_BNM_HI:plectl_pkg::PC_BNM_LO]; // RL5
                        state_q       <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    line_addr_q <= block_base_q;
                    block_end_q <= block_base_q + words_to_bytes(len_q)
                                   + plectl_pkg::WORD_BYTES; // RL15
                    state_q     <= ST_ISSUE;
                end
                ST_ISSUE: begin
                    if (!req_q && pace_ready && !paused_q) begin
                        req_q <= 1'b1; // RL6
                    end else if (line_done) begin
                        req_q <= 1'b0;
                        if (!last_line) begin
                            line_addr_q <= line_addr_q + plectl_pkg::LINE_BYTES; // RL23
                        end else if (blocks_left_q != 8'h00) begin
                            blocks_left_q <= blocks_left_q - 8'h01;
                            block_base_q  <= block_end_q
                                             + words_to_bytes({6'h00, stride_q}); // RL16 RL23
                            state_q       <= ST_LOAD;
                        end else begin
                            state_q <= ST_IDLE; // RL23
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign line_prefetch_request = req_q;
    assign line_prefetch_addr    = line_addr_q;
    assign activity_status       = (state_q != ST_IDLE); // RL21

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_overflow_event: assert property (@(posedge mclk) disable iff (rst) // RL18
        (op_valid && allowed && op_sel == plectl_pkg::OP_PROGRAM && q_full)
        |=> fifo_overflow_event)
        else $error("overflow not flagged");

    a_undef_unpriv: assert property (@(posedge mclk) disable iff (rst) // RL3
        (op_valid && priv_only && !op_privileged) |=> op_undef)
        else $error("user access to parameter register not refused");

    a_pause_holds: assert property (@(posedge mclk) disable iff (rst) // RL10
        (op_valid && allowed && op_sel == plectl_pkg::OP_PAUSE) |=> paused)
        else $error("pause not taken");

    a_resume_idle: assert property (@(posedge mclk) disable iff (rst) // RL11
        (!paused && !(op_valid && op_sel == plectl_pkg::OP_PAUSE)) |=> !paused)
        else $error("resume changed unpaused engine");

    a_kill_stops: assert property (@(posedge mclk) disable iff (rst) // RL12
        (op_valid && allowed && op_sel == plectl_pkg::OP_KILL) |=> !line_prefetch_request)
        else $error("kill left request active");

    a_kill_keeps_q: assert property (@(posedge mclk) disable iff (rst) // RL12
        (op_valid && allowed && op_sel == plectl_pkg::OP_KILL && q_not_empty)
        |=> q_not_empty)
        else $error("kill touched queue");

    a_flush_clears: assert property (@(posedge mclk) disable iff (rst) // RL9
        (op_valid && allowed && op_sel == plectl_pkg::OP_FLUSH)
        |=> (free_cnt == 5'(plectl_pkg::FIFO_DEPTH)) && !activity_status)
        else $error("flush incomplete");

    a_wait_gap: assert property (@(posedge mclk) disable iff (rst) // RL6
        (line_done && param_q[7:0] != 8'h00 && !$changed(param_q)) |=> !line_prefetch_request [*2])
        else $error("wait states not honoured");

    a_free_count: assert property (@(posedge mclk) disable iff (rst) // RL19
        free_cnt <= 5'(plectl_pkg::FIFO_DEPTH))
        else $error("free count out of range");
endmodule

// *** verif/plectl_l2_model.sv ***
`timescale 1ns/1ps

// --------------------------------------------------------------
// memory side: takes or aborts one line request at a time
// --------------------------------------------------------------
module plectl_l2_model (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic line_prefetch_request,
    input  wire logic stall,
    input  wire logic abort_en,
    output logic      line_prefetch_accept,
    output logic      line_prefetch_abort
);
    logic take;

    // a one-cycle answer is never repeated for the same request
    assign take = line_prefetch_request & ~line_prefetch_accept & ~line_prefetch_abort & ~stall;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            line_prefetch_accept <= 1'b0;
            line_prefetch_abort  <= 1'b0;
        end else begin
            line_prefetch_accept <= take & ~abort_en;
            line_prefetch_abort  <= take & abort_en;
        end
    end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps

module testbench;
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    plectl_pkg::plectl_op_t sel = plectl_pkg::OP_NONE;
    logic        mclk = 1'b0, rst = 1'b1, vld = 1'b0, pr = 1'b1, ns = 1'b0, pm = 1'b0;
    logic        stall = 1'b0, ab = 1'b0, done, und, req, acc, abt, ovf, act, pau;
    logic        dn, ud, ov;
    logic [31:0] lo = 32'h0000_0000, hi = 32'h0000_0000, rdata, addr, rd, v;
    logic [31:0] seed = 32'h0855_e002;
    int          failures = 0, checked = 0;

    always #2 mclk = ~mclk;

    plectl_top plectl_top_inst (.mclk(mclk), .rst(rst), .op_valid(vld), .op_sel(sel),
        .op_wdata_lo(lo), .op_wdata_hi(hi), .op_privileged(pr), .op_nonsecure(ns),
        .nonsecure_preload_permit(pm), .op_done(done), .op_undef(und), .op_rdata(rdata),
        .line_prefetch_request(req), .line_prefetch_addr(addr),
        .line_prefetch_accept(acc), .line_prefetch_abort(abt),
        .fifo_overflow_event(ovf), .activity_status(act), .paused(pau));

    plectl_l2_model plectl_l2_model_inst (.mclk(mclk), .rst(rst),
        .line_prefetch_request(req), .stall(stall), .abort_en(ab),
        .line_prefetch_accept(acc), .line_prefetch_abort(abt));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // memory side answers at random speed, now and then aborting
    always @(posedge mclk) begin
        #1;
        seed = lfsr(seed);
        stall = seed[3];
        ab = seed[4] & seed[9];
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic op(input plectl_pkg::plectl_op_t s, input logic [31:0] l, input logic [31:0] h);
        @(posedge mclk);
        #1;
        vld = 1'b1;
        sel = s;
        lo = l;
        hi = h;
        @(posedge mclk);
        #1;
        vld = 1'b0;
        dn = done;
        ud = und;
        ov = ovf;
        rd = rdata;
    endtask

    task automatic wait_for(input int bit_sel, output int n);
        for (n = 0; (bit_sel == 0) ? (req !== 1'b1) : (acc !== 1'b1 && abt !== 1'b1); n++) begin
            if (n > 700) begin
                failures++;
                give_verdict();
            end
            @(posedge mclk);
            #1;
        end
    endtask

    // program one channel and follow its lines; pc gives masks and wait states
    task automatic walk(input logic [31:0] base, input logic [13:0] ln, input logic [7:0] st,
                        input logic [7:0] nb, input logic [31:0] pc);
        logic [31:0] a, e, x;
        logic [13:0] el;
        logic [7:0]  en;
        int          n;
        bit          first;
        el = ln & pc[29:16];
        en = nb & pc[15:8];
        first = 1;
        a = base;
        op(plectl_pkg::OP_WR_PARAM, pc, 32'h0000_0000);
        op(plectl_pkg::OP_PROGRAM, {ln, st, nb, 2'b11}, {base[31:2], 2'b11});
        chk(dn, 1'b1);
        for (int b = 0; b <= en; b++) begin
            e = a + ((32'(el) + 1) << 2);
            x = a;
            do begin
                wait_for(0, n);
                if (!first) chk(n > pc[7:0], 1'b1);
                chk(addr, x);
                first = 0;
                wait_for(1, n);
                @(posedge mclk);
                #1;
                x = x + plectl_pkg::LINE_BYTES;
            end while (x < e);
            a = e + (32'(st) << 2);
        end
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        op(plectl_pkg::OP_RD_USER_ACCESS, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        op(plectl_pkg::OP_RD_ID, 32'h0000_0000, 32'h0000_0000);
        chk(rd, (plectl_pkg::FIFO_DEPTH << 16) | 1);
        v = seed;
        op(plectl_pkg::OP_WR_PARAM, v, 32'h0000_0000);
        op(plectl_pkg::OP_RD_PARAM, 32'h0000_0000, 32'h0000_0000);
        chk(rd, v & 32'h3fff_ffff);
        pr = 1'b0;
        op(plectl_pkg::OP_RD_PARAM, 32'h0000_0000, 32'h0000_0000);
        chk(ud, 1'b1);
        op(plectl_pkg::OP_PAUSE, 32'h0000_0000, 32'h0000_0000);
        chk(ud, 1'b1);
        pr = 1'b1;
        op(plectl_pkg::OP_WR_USER_ACCESS, 32'hffff_ffff, 32'h0000_0000);
        op(plectl_pkg::OP_RD_USER_ACCESS, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        pr = 1'b0;
        ns = 1'b1;
        op(plectl_pkg::OP_RESUME, 32'h0000_0000, 32'h0000_0000);
        chk(ud, 1'b1);
        pm = 1'b1;
        op(plectl_pkg::OP_RESUME, 32'h0000_0000, 32'h0000_0000);
        chk({dn, pau}, 2'b10);
        ns = 1'b0;
        pr = 1'b1;
        walk(seed & 32'h0fff_ffe0, 14'h000f, 8'h02, 8'h01, 32'h3fff_ff03);
        walk(seed & 32'h0fff_ffe0, 14'h003f, 8'h05, 8'h03, 32'h0007_0000);
        // paused engine keeps programmed channels queued until overflow
        op(plectl_pkg::OP_PAUSE, 32'h0000_0000, 32'h0000_0000);
        chk(pau, 1'b1);
        for (int i = 0; i <= plectl_pkg::FIFO_DEPTH; i++) begin
            op(plectl_pkg::OP_PROGRAM, seed, seed);
            chk(ov, i == plectl_pkg::FIFO_DEPTH);
            op(plectl_pkg::OP_RD_FREE, 32'h0000_0000, 32'h0000_0000);
            chk(rd, (i < plectl_pkg::FIFO_DEPTH) ? plectl_pkg::FIFO_DEPTH - 1 - i : 0);
        end
        chk(req, 1'b0);
        op(plectl_pkg::OP_RD_ACTIVITY, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        op(plectl_pkg::OP_RESUME, 32'h0000_0000, 32'h0000_0000);
        op(plectl_pkg::OP_RD_ACTIVITY, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        op(plectl_pkg::OP_KILL, 32'h0000_0000, 32'h0000_0000);
        op(plectl_pkg::OP_RD_FREE, 32'h0000_0000, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        op(plectl_pkg::OP_FLUSH, seed, 32'h0000_0000);
        op(plectl_pkg::OP_RD_FREE, 32'h0000_0000, 32'h0000_0000);
        chk(rd, plectl_pkg::FIFO_DEPTH);
        op(plectl_pkg::OP_RESUME, 32'h0000_0000, 32'h0000_0000);
        repeat (20) @(posedge mclk);
        #1;
        chk({req, act, pau}, 3'b000);
        give_verdict();
    end
endmodule
